// *** include/afs_defines.svh ***
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH
// gain select codes
`define AFS_GAIN_0P4 2'h0
`define AFS_GAIN_0P8 2'h1
`define AFS_GAIN_1P6 2'h2
// commutation type codes (2 bits; code 2 is refused)
`define AFS_COMM_SINE 2'h0
`define AFS_COMM_BRUSH 2'h1
`define AFS_COMM_EXT 2'h3
// command limit in millivolts when gain code 2 is active
`define AFS_LIMIT_MV 16'h1388
`define AFS_FULL_MV 16'h2710
// fault query selectors
`define AFS_SEL_SUPPLY 2'h0
`define AFS_SEL_CONT 2'h2
`define AFS_SEL_ESTOP 2'h3
`define AFS_ESTOP_CODE 8'h03
// bit positions in the supply/current status byte
`define AFS_BIT_UV 0
`define AFS_BIT_OV 1
`define AFS_BIT_OC01 2
`define AFS_BIT_OC23 3
`define AFS_BIT_OT 4
`endif

// *** include/afs_pkg.sv ***
package afs_pkg;
	typedef enum logic [1:0] {
		AFS_AX_OFF = 2'b00,
		AFS_AX_READY = 2'b01,
		AFS_AX_ON = 2'b10
	} afs_axis_state_t;
	// raw comparator levels from the sensing circuits
	typedef struct packed {
		logic under_v;
		logic over_v;
		logic [1:0] over_i;
		logic over_t;
	} afs_sense_t;
	// one host command
	typedef struct packed {
		logic [1:0] axis;
		logic off;
		logic enable;
		logic set_gain;
		logic [1:0] gain;
		logic set_loop;
		logic [2:0] loop_gain;
		logic set_comm;
		logic [1:0] comm;
		logic set_cpc;
		logic [15:0] cpc;
		logic init_done;
	} afs_cmd_t;
endpackage

// *** rtl/afs_sync.sv ***
`timescale 1ns/1ns
// two-flop synchroniser for a group of levels
module afs_sync #(
	parameter int W = 5
) (
	// clock
	input wire logic mclk,
	input wire logic reset,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	// first stage feeds only the second
	always_comb begin
		next_meta = async_in;
		next_sync = meta;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync;
		end
	end
endmodule

// *** rtl/afs_supervisor.sv ***
`timescale 1ns/1ns
`include "afs_defines.svh"
module afs_supervisor (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// host command port
	input wire logic cmd_valid,
	input wire afs_pkg::afs_cmd_t cmd,
	// phase lock sequencing from the commutation engine
	input wire logic phase_lock_init,
	input wire logic min_move_init,
	// program state for the fault handler
	input wire logic thread0_running,
	input wire logic fault_handler_label,
	input wire logic pos_error_over,
	// pins from the sensing circuits and estop
	input wire logic estop_input,
	input wire afs_pkg::afs_sense_t sense,
	input wire logic [7:0] cont_exceed,
	// fault query
	input wire logic [1:0] query_sel,
	output logic [7:0] amp_fault_query,
	// per-axis outputs, then the handler start pulse
	output logic [3:0] amp_enable,
	output logic [3:0] drive_off_state,
	output logic [3:0] brushed_mode,
	output logic [7:0] amp_gain_select,
	output logic [11:0] current_loop_gain,
	output logic [63:0] counts_per_cycle,
	output logic [63:0] command_voltage_limit,
	output logic handler_start
);
	localparam int NAX = 4;

	logic [5:0] sync_out;
	logic estop;
	afs_pkg::afs_sense_t s;
	afs_pkg::afs_axis_state_t st [NAX];
	afs_pkg::afs_axis_state_t next_st [NAX];
	logic [1:0] gain [NAX];
	logic [1:0] next_gain [NAX];
	logic [2:0] loopg [NAX];
	logic [2:0] next_loopg [NAX];
	logic [1:0] comm [NAX];
	logic [1:0] next_comm [NAX];
	logic [15:0] cpc [NAX];
	logic [15:0] next_cpc [NAX];
	logic [NAX-1:0] inited;
	logic [NAX-1:0] next_inited;
	logic estop_lat;
	logic next_estop_lat;
	logic [1:0] oc_lat;
	logic [1:0] next_oc_lat;
	logic ot_lat;
	logic next_ot_lat;
	logic [7:0] prev_fault;
	logic [7:0] next_prev_fault;
	logic [7:0] query;
	logic [7:0] next_query;
	logic [3:0] en;
	logic [3:0] next_en;
	logic hstart;
	logic next_hstart;
	logic [7:0] fault_vec;
	logic [7:0] handler_vec;

	// comparators and estop are asynchronous pins
	afs_sync #(.W(6)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({estop_input, sense}),
		.sync_out(sync_out)
	);
	assign estop = sync_out[5];
	assign s = sync_out[4:0];

	function automatic logic [15:0] limit_mv(input logic [1:0] g);
		limit_mv = (g == `AFS_GAIN_1P6) ? `AFS_LIMIT_MV : `AFS_FULL_MV;
	endfunction

	function automatic logic pair_oc(input logic [1:0] ocl, input int a);
		pair_oc = (a < 2) ? ocl[0] : ocl[1];
	endfunction

	// status byte for selector 0
	always_comb begin
		fault_vec = 8'h00;
		fault_vec[`AFS_BIT_UV] = s.under_v;
		fault_vec[`AFS_BIT_OV] = s.over_v;
		fault_vec[`AFS_BIT_OC01] = oc_lat[0];
		fault_vec[`AFS_BIT_OC23] = oc_lat[1];
		fault_vec[`AFS_BIT_OT] = ot_lat;
		// events that start the handler; over-voltage left out
		handler_vec = fault_vec;
		handler_vec[`AFS_BIT_OV] = 1'b0;
		handler_vec[5] = estop_lat;
	end

	// axis configuration and state
	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			next_st[a] = st[a];
			next_gain[a] = gain[a];
			next_loopg[a] = loopg[a];
			next_comm[a] = comm[a];
			next_cpc[a] = cpc[a];
			next_inited[a] = inited[a];
			if (cmd_valid && cmd.axis == 2'(a)) begin
				if (cmd.set_gain && st[a] == afs_pkg::AFS_AX_OFF &&
						cmd.gain != 2'h3) begin
					next_gain[a] = cmd.gain;
				end
				if (cmd.set_loop && st[a] == afs_pkg::AFS_AX_OFF &&
						cmd.loop_gain <= 3'h4) begin
					next_loopg[a] = cmd.loop_gain;
				end
				if (cmd.set_comm && cmd.comm != 2'h2) begin
					next_comm[a] = cmd.comm;
				end
				if (cmd.set_cpc) begin
					next_cpc[a] = cmd.cpc;
				end
				if (cmd.init_done && (phase_lock_init || min_move_init)) begin
					next_inited[a] = 1'b1;
				end
				if (cmd.off) begin
					next_st[a] = afs_pkg::AFS_AX_OFF;
				end else if (cmd.enable && (inited[a] ||
						comm[a] == `AFS_COMM_EXT)) begin
					next_st[a] = afs_pkg::AFS_AX_ON;
				end
			end
			// estop forces every axis off
			if (estop) begin
				next_st[a] = afs_pkg::AFS_AX_OFF;
			end
		end
	end

	// latched faults; a new event wins over a clear
	always_comb begin
		next_estop_lat = estop_lat;
		next_oc_lat = oc_lat;
		next_ot_lat = ot_lat;
		if (cmd_valid && cmd.enable) begin
			next_estop_lat = 1'b0;
			if (!s.over_i[0]) next_oc_lat[0] = 1'b0;
			if (!s.over_i[1]) next_oc_lat[1] = 1'b0;
			if (!s.over_t) next_ot_lat = 1'b0;
		end
		if (estop) next_estop_lat = 1'b1;
		if (s.over_i[0]) next_oc_lat[0] = 1'b1;
		if (s.over_i[1]) next_oc_lat[1] = 1'b1;
		if (s.over_t) next_ot_lat = 1'b1;
	end

	// hardware enable: state plus live and latched faults
	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			next_en[a] = (st[a] == afs_pkg::AFS_AX_ON) && !estop &&
				!estop_lat && !s.under_v && !s.over_v &&
				!pair_oc(oc_lat, a) && !s.over_i[a/2] && !ot_lat;
		end
	end

	// handler start on a rising handler event, incl. power-up uv
	always_comb begin
		next_prev_fault = handler_vec;
		next_hstart = thread0_running && fault_handler_label &&
			|(handler_vec & ~prev_fault);
	end

	// query mux; registered, so the answer follows the selector one edge later
	always_comb begin
		unique case (query_sel)
			`AFS_SEL_SUPPLY: next_query = fault_vec;
			`AFS_SEL_CONT: next_query = cont_exceed;
			`AFS_SEL_ESTOP: next_query = estop_lat ? `AFS_ESTOP_CODE : 8'h00;
			default: next_query = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int a = 0; a < NAX; a++) begin
				st[a] <= afs_pkg::AFS_AX_OFF;
				gain[a] <= `AFS_GAIN_0P8;
				loopg[a] <= 3'h0;
				comm[a] <= `AFS_COMM_SINE;
				cpc[a] <= 16'h0000;
			end
			inited <= '0;
			estop_lat <= 1'b0;
			oc_lat <= 2'b00;
			ot_lat <= 1'b0;
			prev_fault <= 8'h00;
			query <= 8'h00;
			en <= 4'h0;
			hstart <= 1'b0;
		end else begin
			st <= next_st;
			gain <= next_gain;
			loopg <= next_loopg;
			comm <= next_comm;
			cpc <= next_cpc;
			inited <= next_inited;
			estop_lat <= next_estop_lat;
			oc_lat <= next_oc_lat;
			ot_lat <= next_ot_lat;
			prev_fault <= next_prev_fault;
			query <= next_query;
			en <= next_en;
			hstart <= next_hstart;
		end
	end

	// flatten per-axis state onto the ports
	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			drive_off_state[a] = (st[a] != afs_pkg::AFS_AX_ON);
			brushed_mode[a] = (comm[a] == `AFS_COMM_BRUSH);
			amp_gain_select[2*a +: 2] = gain[a];
			current_loop_gain[3*a +: 3] = loopg[a];
			counts_per_cycle[16*a +: 16] = cpc[a];
			command_voltage_limit[16*a +: 16] = limit_mv(gain[a]);
		end
	end
	assign amp_enable = en;
	assign amp_fault_query = query;
	assign handler_start = hstart;

	// estop drops every enable within three edges
	estop_off_a: assert property (@(posedge mclk) disable iff (reset)
		estop_input |-> ##[1:3] (amp_enable == 4'h0))
		else $error("estop did not disable amplifier");
	// enable refused without init on a sine axis
	no_init_en_a: assert property (@(posedge mclk) disable iff (reset)
		(cmd_valid && cmd.enable && !cmd.off && cmd.axis == 2'h0 &&
		!inited[0] && comm[0] != `AFS_COMM_EXT && st[0] !=
		afs_pkg::AFS_AX_ON) |=> st[0] != afs_pkg::AFS_AX_ON)
		else $error("enable accepted before init");
	// external drive allows direct enable
	ext_en_a: assert property (@(posedge mclk) disable iff (reset)
		(cmd_valid && cmd.enable && !cmd.off && cmd.axis == 2'h2 &&
		comm[2] == `AFS_COMM_EXT && !estop) |=>
		st[2] == afs_pkg::AFS_AX_ON)
		else $error("external drive enable refused");
	// gain holds while axis on
	gain_hold_a: assert property (@(posedge mclk) disable iff (reset)
		(st[0] == afs_pkg::AFS_AX_ON) |=> $stable(gain[0]))
		else $error("gain changed while axis on");
	// gain 2 limits to 5 volts
	gain_clamp_a: assert property (@(posedge mclk) disable iff (reset)
		amp_gain_select[1:0] == `AFS_GAIN_1P6 |->
		command_voltage_limit[15:0] == `AFS_LIMIT_MV)
		else $error("limit not clamped");
	// estop reports code 3 one edge later
	estop_code_a: assert property (@(posedge mclk) disable iff (reset)
		(estop_lat && query_sel == `AFS_SEL_ESTOP) |=>
		amp_fault_query == `AFS_ESTOP_CODE)
		else $error("estop code missing");
	// over-voltage alone never starts the handler
	ov_nohandler_a: assert property (@(posedge mclk) disable iff (reset)
		(handler_vec == prev_fault) |=> !handler_start)
		else $error("handler started without new fault");
	// over-current keeps latch until an enable
	oc_latch_a: assert property (@(posedge mclk) disable iff (reset)
		(oc_lat[0] && !(cmd_valid && cmd.enable)) |=> oc_lat[0])
		else $error("over-current latch dropped");
	// under-voltage clears enable within three edges
	uv_off_a: assert property (@(posedge mclk) disable iff (reset)
		sense.under_v |-> ##[1:3] (amp_enable == 4'h0))
		else $error("under-voltage did not disable");
endmodule

// *** test/afs_sense_model.sv ***
`timescale 1ns/1ns
// comparator bank between the power stage and the supervisor
module afs_sense_model (
	// analog quantities in whole volts, amps and degrees
	input wire logic [7:0] supply_v,
	input wire logic [7:0] pair01_a,
	input wire logic [7:0] pair23_a,
	input wire logic [7:0] heat_c,
	// comparator levels
	output afs_pkg::afs_sense_t sense
);
	logic ov_band;
	// band latch holds between 90 and 94 volts, so the pin cannot chatter
	initial ov_band = 1'b0;
	always @(supply_v) begin
		if (supply_v > 8'h5e)
			ov_band = 1'b1;
		else if (supply_v < 8'h5a)
			ov_band = 1'b0;
	end
	// threshold comparators, active high; over_v comes from the band latch
	always_comb begin
		sense.under_v = supply_v < 8'h12;
		sense.over_v = ov_band;
		sense.over_i[0] = pair01_a > 8'h14;
		sense.over_i[1] = pair23_a > 8'h14;
		sense.over_t = heat_c > 8'h50;
	end
endmodule

// *** test/afs_supervisor_tb.sv ***
`timescale 1ns/1ns
// bench: host commands, analog levels and fault queries
module afs_supervisor_tb;
	localparam int OFF = 0, EN = 1, GAIN = 2, LOOP = 3, COMM = 4, CPC = 5;
	localparam int INIT = 6;
	logic mclk, reset, cmd_valid, phase_lock_init, min_move_init;
	logic thread0_running, fault_handler_label, estop_input, handler_start;
	afs_pkg::afs_cmd_t cmd;
	afs_pkg::afs_sense_t sense;
	logic [7:0] cont_exceed, amp_fault_query, amp_gain_select, q;
	logic [1:0] query_sel;
	logic [3:0] amp_enable, drive_off_state, brushed_mode;
	logic [11:0] current_loop_gain;
	logic [63:0] counts_per_cycle, command_voltage_limit;
	logic [7:0] supply_v, pair01_a, pair23_a, heat_c;
	int errors = 0;
	int checked = 0;
	int pulses = 0;
	int p;
	afs_supervisor DUT (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd(cmd), .phase_lock_init(phase_lock_init),
		.min_move_init(min_move_init), .thread0_running(thread0_running),
		.fault_handler_label(fault_handler_label), .pos_error_over(1'b0),
		.estop_input(estop_input), .sense(sense), .cont_exceed(cont_exceed),
		.query_sel(query_sel), .amp_fault_query(amp_fault_query),
		.amp_enable(amp_enable), .drive_off_state(drive_off_state),
		.brushed_mode(brushed_mode), .amp_gain_select(amp_gain_select),
		.current_loop_gain(current_loop_gain),
		.counts_per_cycle(counts_per_cycle),
		.command_voltage_limit(command_voltage_limit),
		.handler_start(handler_start));
	afs_sense_model sensors (.supply_v(supply_v), .pair01_a(pair01_a),
		.pair23_a(pair23_a), .heat_c(heat_c), .sense(sense));
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// handler pulses last one cycle, so count them as they pass
	always @(negedge mclk) begin
		if (handler_start === 1'b1)
			pulses++;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string what, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// one command for one edge; an idle edge after keeps strobes apart
	task op(input logic [1:0] ax, input int k, input logic [15:0] v);
		cmd = '0;
		cmd.axis = ax;
		case (k)
			OFF: cmd.off = 1'b1;
			EN: cmd.enable = 1'b1;
			GAIN: begin cmd.set_gain = 1'b1; cmd.gain = v[1:0]; end
			LOOP: begin cmd.set_loop = 1'b1; cmd.loop_gain = v[2:0]; end
			COMM: begin cmd.set_comm = 1'b1; cmd.comm = v[1:0]; end
			CPC: begin cmd.set_cpc = 1'b1; cmd.cpc = v; end
			default: cmd.init_done = 1'b1;
		endcase
		cmd_valid = 1'b1;
		step(1);
		cmd_valid = 1'b0;
		step(1);
	endtask
	task rdq(input logic [1:0] sel);
		query_sel = sel;
		step(2);
		q = amp_fault_query;
	endtask
	// pin paths pass a synchroniser, so allow a bounded settling time
	task wait_en(input logic [3:0] m, input logic [3:0] w);
		int i;
		i = 0;
		while (i < 20 && (amp_enable & m) !== w) begin
			step(1);
			i++;
		end
		if (i == 20) begin
			errors++;
			$display("wrong value amp_enable expected %h seen %h", w, amp_enable);
			give_verdict;
		end else
			chk("amp_enable", 64'(w), 64'(amp_enable & m));
	endtask
	initial begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		phase_lock_init = 1'b0;
		min_move_init = 1'b0;
		thread0_running = 1'b1;
		fault_handler_label = 1'b1;
		estop_input = 1'b0;
		cont_exceed = 8'ha5;
		query_sel = 2'h0;
		supply_v = 8'h30;
		pair01_a = 8'h02;
		pair23_a = 8'h02;
		heat_c = 8'h28;
		step(20);
		reset = 1'b0;
		step(1);
		chk("amp_enable", 4'h0, amp_enable);
		chk("drive_off_state", 4'hf, drive_off_state);
		chk("amp_gain_select", 8'h55, amp_gain_select);
		chk("limit", {4{16'h2710}}, command_voltage_limit);
		op(0, EN, 0);
		step(4);
		chk("amp_enable", 4'h0, amp_enable);
		phase_lock_init = 1'b1;
		op(0, INIT, 0);
		op(0, EN, 0);
		wait_en(4'h1, 4'h1);
		phase_lock_init = 1'b0;
		min_move_init = 1'b1;
		op(1, INIT, 0);
		op(1, EN, 0);
		wait_en(4'h2, 4'h2);
		$display("test init gating done");
		op(0, GAIN, 2);
		chk("amp_gain_select", 8'h55, amp_gain_select);
		op(0, OFF, 0);
		op(0, GAIN, 2);
		op(0, LOOP, 3);
		chk("amp_gain_select", 8'h56, amp_gain_select);
		chk("current_loop_gain", 12'h003, current_loop_gain);
		chk("limit", {{3{16'h2710}}, 16'h1388}, command_voltage_limit);
		chk("drive_off_state", 4'hd, drive_off_state);
		for (int g = 0; g < 4; g++) begin
			op(3, GAIN, 16'(g));
			chk("gain3", g < 3 ? g : 2, amp_gain_select[7:6]);
			chk("limit3", g > 1 ? 16'h1388 : 16'h2710,
				command_voltage_limit[63:48]);
		end
		$display("test gains done");
		op(2, COMM, 1);
		chk("brushed_mode", 4'h4, brushed_mode);
		op(2, COMM, 3);
		op(2, EN, 0);
		wait_en(4'h4, 4'h4);
		op(3, COMM, 2);
		op(3, EN, 0);
		step(4);
		chk("amp_enable", 4'h6, amp_enable);
		op(3, CPC, 16'h1388);
		chk("counts_per_cycle", 16'h1388, counts_per_cycle[63:48]);
		op(0, EN, 0);
		wait_en(4'hf, 4'h7);
		$display("test commutation done");
		p = pulses;
		supply_v = 8'h11;
		wait_en(4'hf, 4'h0);
		rdq(0);
		chk("uv bit", 1'b1, q[0]);
		chk("pulses", p + 1, pulses);
		supply_v = 8'h18;
		wait_en(4'hf, 4'h7);
		p = pulses;
		supply_v = 8'h5f;
		wait_en(4'hf, 4'h0);
		rdq(0);
		chk("ov bit", 1'b1, q[1]);
		supply_v = 8'h5c;
		step(6);
		chk("amp_enable", 4'h0, amp_enable);
		supply_v = 8'h59;
		wait_en(4'hf, 4'h7);
		chk("pulses", p, pulses);
		$display("test supply done");
		fault_handler_label = 1'b0;
		p = pulses;
		pair01_a = 8'h15;
		wait_en(4'h3, 4'h0);
		rdq(0);
		chk("oc bit", 1'b1, q[2]);
		pair01_a = 8'h02;
		step(6);
		chk("amp_enable", 2'h0, amp_enable[1:0]);
		op(0, EN, 0);
		op(1, EN, 0);
		wait_en(4'h3, 4'h3);
		heat_c = 8'h51;
		wait_en(4'hf, 4'h0);
		rdq(0);
		chk("ot bit", 1'b1, q[4]);
		heat_c = 8'h28;
		step(6);
		chk("amp_enable", 4'h0, amp_enable);
		chk("pulses", p, pulses);
		// clear the heat latch so the estop drop below is a real change
		op(0, EN, 0);
		wait_en(4'hf, 4'h7);
		$display("test latches done");
		fault_handler_label = 1'b1;
		estop_input = 1'b1;
		wait_en(4'hf, 4'h0);
		rdq(3);
		chk("estop code", 8'h03, q);
		rdq(3);
		chk("estop code", 8'h03, q);
		chk("pulses", p + 1, pulses);
		rdq(2);
		chk("cont code", 8'ha5, q);
		estop_input = 1'b0;
		step(6);
		chk("amp_enable", 4'h0, amp_enable);
		op(0, OFF, 0);
		op(0, EN, 0);
		wait_en(4'h1, 4'h1);
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		op(0, EN, 0);
		step(4);
		chk("amp_enable", 4'h0, amp_enable);
		chk("amp_gain_select", 8'h55, amp_gain_select);
		$display("test estop and reset done");
		give_verdict;
	end
endmodule
